// ==== core/pcf_pkg.sv ====
// Package of offsets, field positions, carrier types and timing for the function config/status bank
//
// Overview of operation
// - Status change flag is one whenever any change bit of that function is one.
// - In I/O interface mode, status change output asserts when a function has change flag and gate both set.
// - Speaker output follows speaker input while a configured function has audio set.
// - Power-down bit drops the power control output and floats that function's signals.
// - Pending bit mirrors the interrupt input; writes do nothing without the protocol bit.
// - With protocol bit set, writing zero to pending re-evaluates inputs and retriggers.
// - Request is the OR of enabled asserted inputs, driven as pulse or level.
// - In level mode, interrupt request output releases once no enabled input stays asserted; a pulse releases when its time is up.
// - Pulse retrigger is high-low-high, at least 0.5 us low; level is low-high-low.
// - Protocol bit writes update both functions; either pending write triggers re-evaluation.
// - Ready change bit sets whenever the live ready bit changes.
// - Live ready bit follows the ready pin always; battery and protect bits absent.
// - Ring event latches on ring input in normal mode; unused for function 0 in LAN.
// - Aux event unused normally; in LAN function 0 latches it from ring input 0.
// - Both latched event bits clear only on a write covering bits 4 and 5.
// - An enabled latched event sets that function's status change flag.
// - Two base bytes per function form a 16-bit I/O base; upper bytes unused.
// - Limit mask ones exclude address lines; zeros compare against the base.
// - Pulse-mode interrupt holds low for 16 function-0 card clock cycles.
// - An interrupt input counts only when that function's interrupt enable is one.
package pcf_pkg;

    // Attribute space offsets
    localparam logic [12:0] OFF_CFG_STAT0 = 13'h1022;
    localparam logic [12:0] OFF_CFG_STAT1 = 13'h1042;
    localparam logic [12:0] OFF_PIN_REP0  = 13'h1024;
    localparam logic [12:0] OFF_PIN_REP1  = 13'h1044;
    localparam logic [12:0] OFF_IO_EVT0   = 13'h1028;
    localparam logic [12:0] OFF_IO_EVT1   = 13'h1048;
    localparam logic [12:0] OFF_BASE_LO0  = 13'h102A;
    localparam logic [12:0] OFF_BASE_LO1  = 13'h104A;
    localparam logic [12:0] OFF_BASE_HI0  = 13'h102C;
    localparam logic [12:0] OFF_BASE_HI1  = 13'h104C;
    localparam logic [12:0] OFF_LIMIT0    = 13'h1032;
    localparam logic [12:0] OFF_LIMIT1    = 13'h1052;

    // Config/status bit positions
    localparam int CS_CHANGED = 7;
    localparam int CS_GATE    = 6;
    localparam int CS_NARROW  = 5;
    localparam int CS_AUDIO   = 3;
    localparam int CS_PDOWN   = 2;
    localparam int CS_INTR    = 1;
    localparam int CS_RETRIG  = 0;
    // Pin replacement bit positions
    localparam int PR_RDY_CHG  = 5;
    localparam int PR_RDY_LIVE = 1;
    // I/O event bit positions
    localparam int EV_AUX     = 5;
    localparam int EV_RING    = 4;
    localparam int EV_AUX_EN  = 1;
    localparam int EV_RING_EN = 0;

    // Timing
    localparam int CLK_MHZ          = 200;
    localparam int IRQ_MIN_LOW_NS   = 500;
    localparam int IRQ_MIN_LOW_CYC  = (IRQ_MIN_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int IRQ_GAP_NS       = 500;
    localparam int IRQ_GAP_CYC      = (IRQ_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int IRQ_PULSE_TICKS  = 16;
    localparam int MCLK0_DIV_DEF    = 10;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Per-function writable config/status bits
    typedef struct packed {
        logic gate;
        logic narrow;
        logic audio;
        logic pdown;
    } pcf_cfg_t;

    typedef enum logic [1:0] {
        IRQ_IDLE,
        IRQ_PULSE,
        IRQ_HELD,
        IRQ_GAP
    } pcf_irq_state_t;

endpackage

// ==== core/pcf_function_bank.sv ====
// Dual-function configuration/status register bank with shared interrupt and I/O window decode
`timescale 1ns/1ps
module pcf_function_bank #(
    parameter int MCLK0_DIV = pcf_pkg::MCLK0_DIV_DEF
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [12:0] attr_addr,
    input  wire logic        attr_wr,
    input  wire logic        attr_rd,
    input  wire logic [7:0]  attr_wdata,
    output logic      [7:0]  attr_rdata,
    input  wire logic        io_interface_mode,
    input  wire logic        lan_mode,
    input  wire logic        level_irq_select,
    input  wire logic [1:0]  function_configured,
    input  wire logic [1:0]  function_irq_enable,
    input  wire logic [1:0]  base_limit_enable,
    input  wire logic [1:0]  function_irq_in,
    input  wire logic [1:0]  ready_in,
    input  wire logic [1:0]  ring_indicate_in_n,
    input  wire logic        speaker_in,
    output logic             speaker_out_n,
    output logic      [1:0]  function_power_ctl,
    output logic      [1:0]  function_io_oe,
    output logic             status_change_n,
    output logic             irq_req_n,
    input  wire logic [15:0] io_addr,
    output logic      [1:0]  io_select
);

    // Per-function hit from a pair of offsets
    function automatic logic [1:0] hit2(input logic [12:0] a, input logic [12:0] o0, input logic [12:0] o1);
        hit2 = {a == o1, a == o0};
    endfunction

    pcf_pkg::pcf_cfg_t      cfg [2];
    pcf_pkg::pcf_irq_state_t state;
    pcf_pkg::pcf_irq_state_t next_state;
    logic                   retrig_bit;
    logic [1:0]             rdy_live;
    logic [1:0]             rdy_chg;
    logic [1:0]             ring_evt;
    logic [1:0]             aux_evt;
    logic [1:0]             ring_en;
    logic [1:0]             aux_en;
    logic [7:0]             base_lo [2];
    logic [7:0]             base_hi [2];
    logic [7:0]             limit   [2];
    logic [15:0]            div_cnt;
    logic                   mclk_tick;
    logic [4:0]             tick_cnt;
    logic [15:0]            cyc_cnt;

    // Register decode
    wire logic [1:0] sel_cs   = hit2(attr_addr, pcf_pkg::OFF_CFG_STAT0, pcf_pkg::OFF_CFG_STAT1);
    wire logic [1:0] sel_pr   = hit2(attr_addr, pcf_pkg::OFF_PIN_REP0, pcf_pkg::OFF_PIN_REP1);
    wire logic [1:0] sel_ev   = hit2(attr_addr, pcf_pkg::OFF_IO_EVT0, pcf_pkg::OFF_IO_EVT1);
    wire logic [1:0] sel_bl   = hit2(attr_addr, pcf_pkg::OFF_BASE_LO0, pcf_pkg::OFF_BASE_LO1);
    wire logic [1:0] sel_bh   = hit2(attr_addr, pcf_pkg::OFF_BASE_HI0, pcf_pkg::OFF_BASE_HI1);
    wire logic [1:0] sel_lm   = hit2(attr_addr, pcf_pkg::OFF_LIMIT0, pcf_pkg::OFF_LIMIT1);
    wire logic [1:0] wr_cs    = sel_cs & {2{attr_wr}};
    wire logic [1:0] wr_pr    = sel_pr & {2{attr_wr}};
    wire logic [1:0] wr_ev    = sel_ev & {2{attr_wr}};

    // Event clear needs bits 4 and 5 written together
    wire logic       evt_clr_data = attr_wdata[pcf_pkg::EV_AUX] & attr_wdata[pcf_pkg::EV_RING];
    wire logic [1:0] evt_clr      = wr_ev & {2{evt_clr_data}};

    // Ready change and event sets
    wire logic [1:0] rdy_edge = ready_in ^ rdy_live;
    wire logic [1:0] ring_act = ~ring_indicate_in_n;
    wire logic [1:0] ring_set = ring_act & {1'b1, ~lan_mode};
    wire logic [1:0] aux_set  = {1'b0, ring_act[0] & lan_mode};

    // Status change flag per function
    wire logic [1:0] changed  = rdy_chg | (ring_evt & ring_en) | (aux_evt & aux_en);
    wire logic [1:0] gates    = {cfg[1].gate, cfg[0].gate};
    wire logic       stschg   = io_interface_mode & |(changed & gates);

    // Interrupt request and retrigger
    wire logic [1:0] irq_live = function_irq_in & function_irq_enable;
    wire logic       irq_req  = |irq_live;
    wire logic       retrig   = |wr_cs & retrig_bit & ~attr_wdata[pcf_pkg::CS_INTR];

    // Power and speaker
    wire logic [1:0] pdowns   = {cfg[1].pdown, cfg[0].pdown};
    wire logic [1:0] audios   = {cfg[1].audio, cfg[0].audio};
    wire logic       spk_on   = |(audios & function_configured);

    // I/O window decode, ones in the limit drop address lines
    wire logic [15:0] base0   = {base_hi[0], base_lo[0]};
    wire logic [15:0] base1   = {base_hi[1], base_lo[1]};
    wire logic [15:0] mask0   = {8'hFF, ~limit[0]};
    wire logic [15:0] mask1   = {8'hFF, ~limit[1]};
    wire logic        win0    = (limit[0] != 8'h00) && ((io_addr & mask0) == (base0 & mask0));
    wire logic        win1    = (limit[1] != 8'h00) && ((io_addr & mask1) == (base1 & mask1));
    wire logic [1:0]  io_hit  = function_configured & ~pdowns &
                                ({win1, win0} | ~base_limit_enable);

    // Read data selection, reserved bits are zero
    function automatic logic [7:0] cs_byte(input pcf_pkg::pcf_cfg_t c, input logic chg, input logic irq,
                                           input logic rb);
        logic [7:0] b;
        b = 8'h00;
        b[pcf_pkg::CS_CHANGED] = chg;
        b[pcf_pkg::CS_GATE]    = c.gate;
        b[pcf_pkg::CS_NARROW]  = c.narrow;
        b[pcf_pkg::CS_AUDIO]   = c.audio;
        b[pcf_pkg::CS_PDOWN]   = c.pdown;
        b[pcf_pkg::CS_INTR]    = irq;
        b[pcf_pkg::CS_RETRIG]  = rb;
        cs_byte = b;
    endfunction

    function automatic logic [7:0] pr_byte(input logic chg, input logic live);
        logic [7:0] b;
        b = 8'h00;
        b[pcf_pkg::PR_RDY_CHG]  = chg;
        b[pcf_pkg::PR_RDY_LIVE] = live;
        pr_byte = b;
    endfunction

    function automatic logic [7:0] ev_byte(input logic ae, input logic re, input logic aen, input logic ren);
        logic [7:0] b;
        b = 8'h00;
        b[pcf_pkg::EV_AUX]     = ae;
        b[pcf_pkg::EV_RING]    = re;
        b[pcf_pkg::EV_AUX_EN]  = aen;
        b[pcf_pkg::EV_RING_EN] = ren;
        ev_byte = b;
    endfunction

    wire logic [7:0] rd_cs0 = cs_byte(cfg[0], changed[0], function_irq_in[0], retrig_bit);
    wire logic [7:0] rd_cs1 = cs_byte(cfg[1], changed[1], function_irq_in[1], retrig_bit);
    wire logic [7:0] rd_pr0 = pr_byte(rdy_chg[0], ready_in[0]);
    wire logic [7:0] rd_pr1 = pr_byte(rdy_chg[1], ready_in[1]);
    wire logic [7:0] rd_ev0 = ev_byte(aux_evt[0], ring_evt[0], aux_en[0], ring_en[0]);
    wire logic [7:0] rd_ev1 = ev_byte(aux_evt[1], ring_evt[1], aux_en[1], ring_en[1]);
    wire logic [7:0] rd_mux =
        sel_cs[0] ? rd_cs0 : sel_cs[1] ? rd_cs1 :
        sel_pr[0] ? rd_pr0 : sel_pr[1] ? rd_pr1 :
        sel_ev[0] ? rd_ev0 : sel_ev[1] ? rd_ev1 :
        sel_bl[0] ? base_lo[0] : sel_bl[1] ? base_lo[1] :
        sel_bh[0] ? base_hi[0] : sel_bh[1] ? base_hi[1] :
        sel_lm[0] ? limit[0] : sel_lm[1] ? limit[1] : 8'h00;

    // Read data register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            attr_rdata <= pcf_pkg::RESET_BYTE;
        end else if (attr_rd) begin
            attr_rdata <= rd_mux;
        end
    end

    // Config/status writable bits; the protocol bit is one shared copy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg[0]     <= '0;
            cfg[1]     <= '0;
            retrig_bit <= 1'b0;
        end else begin
            for (int f = 0; f < 2; f++) begin
                if (wr_cs[f]) begin
                    cfg[f].gate   <= attr_wdata[pcf_pkg::CS_GATE];
                    cfg[f].narrow <= attr_wdata[pcf_pkg::CS_NARROW];
                    cfg[f].audio  <= attr_wdata[pcf_pkg::CS_AUDIO];
                    cfg[f].pdown  <= attr_wdata[pcf_pkg::CS_PDOWN];
                end
            end
            if (|wr_cs) begin
                retrig_bit <= attr_wdata[pcf_pkg::CS_RETRIG];
            end
        end
    end

    // Ready tracking; writing one to the change bit clears it, a new change wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdy_live <= '1;                                                                     // Idle ready level, no false change
            rdy_chg  <= 2'h0;
        end else begin
            rdy_live <= ready_in;
            for (int f = 0; f < 2; f++) begin
                if (rdy_edge[f]) begin
                    rdy_chg[f] <= 1'b1;
                end else if (wr_pr[f] && attr_wdata[pcf_pkg::PR_RDY_CHG]) begin
                    rdy_chg[f] <= 1'b0;
                end
            end
        end
    end

    // Event latches and enables; a set in the clearing cycle wins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ring_evt <= 2'h0;
            aux_evt  <= 2'h0;
            ring_en  <= 2'h0;
            aux_en   <= 2'h0;
        end else begin
            ring_evt <= ring_set | (ring_evt & ~evt_clr);
            aux_evt  <= aux_set | (aux_evt & ~evt_clr);
            for (int f = 0; f < 2; f++) begin
                if (wr_ev[f]) begin
                    ring_en[f] <= attr_wdata[pcf_pkg::EV_RING_EN];
                    aux_en[f]  <= attr_wdata[pcf_pkg::EV_AUX_EN];
                end
            end
        end
    end

    // Base and limit registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            base_lo <= '{default: pcf_pkg::RESET_BYTE};
            base_hi <= '{default: pcf_pkg::RESET_BYTE};
            limit   <= '{default: pcf_pkg::RESET_BYTE};
        end else begin
            for (int f = 0; f < 2; f++) begin
                if (attr_wr && sel_bl[f]) base_lo[f] <= attr_wdata;
                if (attr_wr && sel_bh[f]) base_hi[f] <= attr_wdata;
                if (attr_wr && sel_lm[f]) limit[f]   <= attr_wdata;
            end
        end
    end

    // Function-0 card clock enable from a divider
    assign mclk_tick = (div_cnt == 16'(MCLK0_DIV - 1));
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= mclk_tick ? 16'h0000 : div_cnt + 16'h0001;
        end
    end

    // Interrupt state timing; the first card clock tick is partial, so one extra tick keeps 16 whole periods
    wire logic pulse_done = (tick_cnt > 5'(pcf_pkg::IRQ_PULSE_TICKS)) &&
                            (cyc_cnt >= 16'(pcf_pkg::IRQ_MIN_LOW_CYC));
    wire logic gap_done   = cyc_cnt >= 16'(pcf_pkg::IRQ_GAP_CYC);

    // Interrupt state choice
    always_comb begin
        next_state = state;
        unique case (state)
            pcf_pkg::IRQ_IDLE:  if (irq_req) next_state = level_irq_select ? pcf_pkg::IRQ_HELD
                                                                         : pcf_pkg::IRQ_PULSE;
            pcf_pkg::IRQ_PULSE: if (pulse_done) next_state = pcf_pkg::IRQ_HELD;
            pcf_pkg::IRQ_HELD: begin
                if (!irq_req) begin
                    next_state = pcf_pkg::IRQ_IDLE;
                end else if (retrig) begin
                    next_state = level_irq_select ? pcf_pkg::IRQ_GAP : pcf_pkg::IRQ_PULSE;
                end
            end
            pcf_pkg::IRQ_GAP:   if (gap_done) next_state = irq_req ? pcf_pkg::IRQ_HELD
                                                                   : pcf_pkg::IRQ_IDLE;
        endcase
    end

    // Low in pulse, and in held while level mode is selected
    wire logic next_irq_n = !((next_state == pcf_pkg::IRQ_PULSE) ||
                              (next_state == pcf_pkg::IRQ_HELD && level_irq_select));

    // Interrupt state and counters, restarted on every state change
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state     <= pcf_pkg::IRQ_IDLE;
            tick_cnt  <= 5'h00;
            cyc_cnt   <= 16'h0000;
            irq_req_n <= 1'b1;
        end else begin
            state     <= next_state;
            irq_req_n <= next_irq_n;
            if (next_state != state) begin
                tick_cnt <= 5'h00;
                cyc_cnt  <= 16'h0000;
            end else begin
                if (mclk_tick && tick_cnt != 5'h1F) tick_cnt <= tick_cnt + 5'h01;
                if (cyc_cnt != 16'hFFFF) cyc_cnt <= cyc_cnt + 16'h0001;
            end
        end
    end

    // Pin outputs
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            status_change_n    <= 1'b1;
            speaker_out_n      <= 1'b1;
            function_power_ctl <= 2'h0;
            function_io_oe     <= 2'h0;
            io_select          <= 2'h0;
        end else begin
            status_change_n    <= ~stschg;
            speaker_out_n      <= spk_on ? speaker_in : 1'b1;
            function_power_ctl <= ~pdowns;
            function_io_oe     <= ~pdowns;
            io_select          <= io_hit;
        end
    end

endmodule // pcf_function_bank

// ==== verification/pcf_checker.sv ====
// Port-level checker for the function config/status bank, bound to the bank module
`timescale 1ns/1ps
module pcf_checker #(
    parameter int MCLK0_DIV = 10
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       io_interface_mode,
    input wire logic       level_irq_select,
    input wire logic [1:0] function_configured,
    input wire logic [1:0] function_irq_enable,
    input wire logic [1:0] function_irq_in,
    input wire logic       speaker_in,
    input wire logic       speaker_out_n,
    input wire logic [1:0] function_power_ctl,
    input wire logic [1:0] function_io_oe,
    input wire logic       status_change_n,
    input wire logic       irq_req_n,
    input wire logic [1:0] io_select
);
    localparam int LOW_MIN = (16 * MCLK0_DIV > 100) ? 16 * MCLK0_DIV : 100;
    localparam int LOW_MAX = LOW_MIN + MCLK0_DIV + 2;
    wire        irq_req;
    logic [11:0] low_cnt;
    // Merged request of enabled, asserted function inputs
    assign irq_req = |(function_irq_in & function_irq_enable);
    // Length of the current low phase of the host interrupt line
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b)
            low_cnt <= 12'h000;
        else
            low_cnt <= irq_req_n ? 12'h000 : low_cnt + 12'h001;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_req_rise; $rose(irq_req) ##0 level_irq_select; endsequence
    sequence s_req_fall; $fell(irq_req) ##0 level_irq_select; endsequence
    property p_irq_assert; s_req_rise |=> !irq_req_n; endproperty
    property p_irq_release; s_req_fall |=> irq_req_n; endproperty
    property p_irq_cause; $fell(irq_req_n) && level_irq_select |-> $past(irq_req); endproperty
    property p_pulse_min; $rose(irq_req_n) && !level_irq_select |-> low_cnt >= LOW_MIN; endproperty
    property p_pulse_max; !level_irq_select |-> low_cnt <= LOW_MAX; endproperty
    property p_oe_pwr; function_io_oe == function_power_ctl; endproperty
    property p_sel_cfg; (io_select & ~($past(function_configured) & function_power_ctl)) == 2'b00; endproperty
    property p_stat_mode; !$past(io_interface_mode) |-> status_change_n; endproperty
    property p_spk; !speaker_out_n |-> !$past(speaker_in) && $past(function_configured) != 2'b00; endproperty
    a_irq_assert: assert property (p_irq_assert) else $error("request not raised");
    a_irq_release: assert property (p_irq_release) else $error("request not released");
    a_irq_cause: assert property (p_irq_cause) else $error("request without cause");
    a_pulse_min: assert property (p_pulse_min) else $error("pulse too short");
    a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
    a_oe_pwr: assert property (p_oe_pwr) else $error("enable differs from power");
    a_sel_cfg: assert property (p_sel_cfg) else $error("select while off");
    a_stat_mode: assert property (p_stat_mode) else $error("status change outside io mode");
    a_spk: assert property (p_spk) else $error("speaker mismatch");
endmodule // pcf_checker

bind pcf_function_bank pcf_checker #(.MCLK0_DIV(MCLK0_DIV)) u_pcf_checker (
    .clk(clk), .rst_b(rst_b), .io_interface_mode(io_interface_mode), .level_irq_select(level_irq_select),
    .function_configured(function_configured), .function_irq_enable(function_irq_enable),
    .function_irq_in(function_irq_in), .speaker_in(speaker_in), .speaker_out_n(speaker_out_n),
    .function_power_ctl(function_power_ctl), .function_io_oe(function_io_oe),
    .status_change_n(status_change_n), .irq_req_n(irq_req_n), .io_select(io_select));

// ==== verification/pcf_func_model.sv ====
// Behavioural model of the two card functions behind the bank
`timescale 1ns/1ps
module pcf_func_model (
    input  wire logic       clk,
    input  wire logic [1:0] irq_cmd,
    input  wire logic [1:0] rdy_cmd,
    input  wire logic [1:0] ring_cmd,
    input  wire logic [1:0] function_power_ctl,
    output logic      [1:0] function_irq_in,
    output logic      [1:0] ready_in,
    output logic      [1:0] ring_indicate_in_n
);
    // Lines move just after the edge; an unpowered function raises no interrupt
    always @(posedge clk) begin
        function_irq_in <= #1 irq_cmd & function_power_ctl;
        ready_in <= #1 rdy_cmd;
        ring_indicate_in_n <= #1 ~ring_cmd;
    end
endmodule // pcf_func_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the function config/status bank
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {logic wr; logic [12:0] addr; logic [7:0] wd; logic [7:0] exp;} pcf_row_t;
    logic        clk = 1'b0, rst_b = 1'b0, attr_wr = 1'b0, attr_rd = 1'b0;
    logic [12:0] attr_addr = 13'h0000;
    logic [7:0]  attr_wdata = 8'h00, attr_rdata;
    logic        io_mode = 1'b1, lan_mode = 1'b0, level_sel = 1'b1, speaker_in = 1'b1;
    logic [1:0]  cfgd = 2'b11, irq_en = 2'b00, bl_en = 2'b01, irq_cmd = 2'b00, rdy_cmd = 2'b11, ring_cmd = 2'b00;
    logic [1:0]  irq_in, rdy_in, ring_n, pwr, oe, sel;
    logic        spk_n, stat_n, irq_n;
    logic [15:0] io_addr = 16'h0000;
    logic [15:0] addrs [4] = '{16'h03F8, 16'h03FF, 16'h03F7, 16'h0400};
    logic [3:0]  hits = 4'b0011;
    int          err_total = 0, tests_run = 0, n;
    pcf_row_t    rows [11] = '{
        '{1'b1, pcf_pkg::OFF_PIN_REP0, 8'hFF, 8'h02},
        '{1'b1, pcf_pkg::OFF_PIN_REP1, 8'hFF, 8'h02},
        '{1'b1, pcf_pkg::OFF_CFG_STAT0, 8'hFF, 8'h6D},
        '{1'b1, pcf_pkg::OFF_CFG_STAT1, 8'h00, 8'h00},
        '{1'b0, pcf_pkg::OFF_CFG_STAT0, 8'h00, 8'h6C},
        '{1'b1, pcf_pkg::OFF_CFG_STAT0, 8'h00, 8'h00},
        '{1'b1, pcf_pkg::OFF_BASE_LO0, 8'hFF, 8'hFF},
        '{1'b1, pcf_pkg::OFF_BASE_HI0, 8'h03, 8'h03},
        '{1'b1, pcf_pkg::OFF_LIMIT0, 8'h07, 8'h07},
        '{1'b1, pcf_pkg::OFF_IO_EVT0, 8'hFF, 8'h03},
        '{1'b1, 13'h102E, 8'h5A, 8'h00}};
    // Free-running 200 MHz clock
    always #2.5 clk = ~clk;
    pcf_function_bank #(.MCLK0_DIV(10)) u_pcf_function_bank (
        .clk(clk), .rst_b(rst_b), .attr_addr(attr_addr), .attr_wr(attr_wr), .attr_rd(attr_rd),
        .attr_wdata(attr_wdata), .attr_rdata(attr_rdata), .io_interface_mode(io_mode), .lan_mode(lan_mode),
        .level_irq_select(level_sel), .function_configured(cfgd), .function_irq_enable(irq_en),
        .base_limit_enable(bl_en), .function_irq_in(irq_in), .ready_in(rdy_in), .ring_indicate_in_n(ring_n),
        .speaker_in(speaker_in), .speaker_out_n(spk_n), .function_power_ctl(pwr), .function_io_oe(oe),
        .status_change_n(stat_n), .irq_req_n(irq_n), .io_addr(io_addr), .io_select(sel));
    pcf_func_model u_pcf_func_model (.clk(clk), .irq_cmd(irq_cmd), .rdy_cmd(rdy_cmd), .ring_cmd(ring_cmd),
        .function_power_ctl(pwr), .function_irq_in(irq_in), .ready_in(rdy_in), .ring_indicate_in_n(ring_n));
    // Shared comparison, bus cycles, waits and reporting
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        attr_addr = a;
        attr_wdata = d;
        attr_wr = 1'b1;
        @(posedge clk) #1;
        attr_wr = 1'b0;
    endtask
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        @(posedge clk) #1;
        attr_addr = a;
        attr_rd = 1'b1;
        @(posedge clk) #1;
        attr_rd = 1'b0;
        chk(attr_rdata, e);
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic done(input string s);
        $display("Test %s finished at %0t", s, $time);
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_of_test();
    end
    // Main sequence
    initial begin
        tick(12);
        rst_b = 1'b1;
        chk({2'b00, pwr, oe, sel}, 8'h00);
        foreach (rows[i]) begin
            if (rows[i].wr)
                wr(rows[i].addr, rows[i].wd);
            rd(rows[i].addr, rows[i].exp);
        end
        done("register rows");
        foreach (addrs[i]) begin
            io_addr = addrs[i];
            tick(2);
            chk({6'h00, sel}, {6'h00, 1'b1, hits[i]});
        end
        io_addr = 16'h03F8;
        wr(pcf_pkg::OFF_CFG_STAT0, 8'h04);
        tick(2);
        chk({2'b00, pwr, oe, sel}, 8'h2A);
        wr(pcf_pkg::OFF_CFG_STAT0, 8'h00);
        tick(2);
        chk({2'b00, pwr, oe, sel}, 8'h3F);
        speaker_in = 1'b0;
        wr(pcf_pkg::OFF_CFG_STAT1, 8'h08);
        tick(2);
        chk({7'h00, spk_n}, 8'h00);
        cfgd = 2'b01;
        tick(2);
        chk({7'h00, spk_n}, 8'h01);
        cfgd = 2'b11;
        speaker_in = 1'b1;
        done("decode power speaker");
        wr(pcf_pkg::OFF_IO_EVT1, 8'h01);
        wr(pcf_pkg::OFF_CFG_STAT1, 8'h40);
        ring_cmd = 2'b10;
        tick(1);
        ring_cmd = 2'b00;
        tick(3);
        rd(pcf_pkg::OFF_IO_EVT1, 8'h11);
        rd(pcf_pkg::OFF_CFG_STAT1, 8'hC0);
        chk({7'h00, stat_n}, 8'h00);
        io_mode = 1'b0;
        tick(2);
        chk({7'h00, stat_n}, 8'h01);
        io_mode = 1'b1;
        wr(pcf_pkg::OFF_IO_EVT1, 8'h11);
        rd(pcf_pkg::OFF_IO_EVT1, 8'h11);
        wr(pcf_pkg::OFF_IO_EVT1, 8'h31);
        rd(pcf_pkg::OFF_IO_EVT1, 8'h01);
        chk({7'h00, stat_n}, 8'h01);
        lan_mode = 1'b1;
        ring_cmd = 2'b01;
        tick(1);
        ring_cmd = 2'b00;
        tick(3);
        rd(pcf_pkg::OFF_IO_EVT0, 8'h23);
        lan_mode = 1'b0;
        wr(pcf_pkg::OFF_IO_EVT0, 8'h30);
        rdy_cmd = 2'b10;
        tick(3);
        rd(pcf_pkg::OFF_PIN_REP0, 8'h20);
        rd(pcf_pkg::OFF_CFG_STAT0, 8'h80);
        rdy_cmd = 2'b11;
        tick(3);
        wr(pcf_pkg::OFF_PIN_REP0, 8'h20);
        rd(pcf_pkg::OFF_PIN_REP0, 8'h02);
        done("events and ready");
        irq_en = 2'b01;
        irq_cmd = 2'b10;
        tick(3);
        chk({7'h00, irq_n}, 8'h01);
        rd(pcf_pkg::OFF_CFG_STAT1, 8'h42);
        irq_cmd = 2'b11;
        tick(3);
        chk({7'h00, irq_n}, 8'h00);
        wr(pcf_pkg::OFF_CFG_STAT0, 8'h01);
        tick(1);
        chk({7'h00, irq_n}, 8'h00);
        wr(pcf_pkg::OFF_CFG_STAT1, 8'h01);
        tick(2);
        chk({7'h00, irq_n}, 8'h01);
        tick(110);
        chk({7'h00, irq_n}, 8'h00);
        irq_en = 2'b11;
        irq_cmd = 2'b10;
        tick(3);
        chk({7'h00, irq_n}, 8'h00);
        irq_cmd = 2'b00;
        tick(3);
        chk({7'h00, irq_n}, 8'h01);
        wr(pcf_pkg::OFF_CFG_STAT0, 8'h00);
        level_sel = 1'b0;
        irq_cmd = 2'b01;
        tick(3);
        n = 0;
        while (irq_n === 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        chk(8'((n >= 158) && (n <= 170)), 8'h01);
        wr(pcf_pkg::OFF_CFG_STAT0, 8'h01);
        wr(pcf_pkg::OFF_CFG_STAT1, 8'h00);
        tick(2);
        chk({7'h00, irq_n}, 8'h00);
        tick(170);
        chk({7'h00, irq_n}, 8'h01);
        irq_cmd = 2'b00;
        tick(4);
        done("interrupts");
        end_of_test();
    end
endmodule // tb_top
